// ==== include/dtf_regs.svh ====
// Register addresses, field positions and reset values of the disk task file
// Functional notes
// - Control bits 7..3 reserved, ignored by device
// - Soft reset bit holds device in reset
// - Irq enabled when not disabled and selected
// - Irq released when disabled or unselected
// - Addressing bit: zero CHS, one LBA
// - Drive pick bit; only selected drive responds
// - Head field: head or address bits 27-24
// - Failed media access rewrites head field
// - Error causes meaningful only with error flag
// - Reset or diagnostic loads diagnostic code
// - Separate error cause bits per failure
// - Media change rejects first command once
// - Removal request errors door-lock until cleared
// - Feature register holds command parameter only
// - Sector count zero means 256 sectors
// - Count zero on success, remainder on failure; code zeroes it on OK and door-clear only, remainder only on media error
// - Sector number: start sector or address 7-0
// - Failed media access rewrites sector number
// - Command block writes ignored while busy
// - Status bit 0 flags previous command error
`ifndef DTF_REGS_SVH
`define DTF_REGS_SVH
// Control block address (cs1 asserted)
`define DTF_ADDR_CONTROL 3'h6
// Command block addresses (cs0 asserted)
`define DTF_ADDR_ERROR 3'h1
`define DTF_ADDR_COUNT 3'h2
`define DTF_ADDR_SECTOR 3'h3
`define DTF_ADDR_DRVHEAD 3'h6
`define DTF_ADDR_STATUS 3'h7
// Control fields
`define DTF_CTL_SOFT_RESET_BIT 2
`define DTF_CTL_IRQ_DISABLE_BIT 1
// Drive/head fields
`define DTF_DH_LBA 6
`define DTF_DH_DEV 4
`define DTF_DH_HEAD_TOP 3
`define DTF_DH_HEAD_BOT 0
`define DTF_DH_FIXED 8'hA0
// Error cause bits
`define DTF_ERR_UNC 6
`define DTF_ERR_MC 5
`define DTF_ERR_SECTOR_ID_MISSING 4
`define DTF_ERR_MCR 3
`define DTF_ERR_COMMAND_ABORTED_FLAG 2
`define DTF_ERR_TK0 1
`define DTF_ERR_DATA_MARK_MISSING 0
// Status bits
`define DTF_ST_BSY 7
`define DTF_ST_ERR 0
// Reset values
`define DTF_DIAG_PASS 8'h01
`define DTF_RST_COUNT 8'h01
`define DTF_RST_SECTOR 8'h01
`define DTF_RST_DRVHEAD 8'h00
`define DTF_RST_CONTROL 8'h00
`endif

// ==== include/dtf_pkg.sv ====
// Types of the disk task file register bank
package dtf_pkg;
  typedef enum logic [1:0] {
    DTF_IDLE,
    DTF_BUSY,
    DTF_RESET
  } dtf_state_type;

  typedef enum logic [2:0] {
    DTF_RES_OK,
    DTF_RES_MEDIA_ERR,
    DTF_RES_ABORT,
    DTF_RES_DOOR_LOCK,
    DTF_RES_DOOR_CLEAR,
    DTF_RES_DIAG
  } dtf_result_type;
endpackage

// ==== logic/dtf_err_track.sv ====
// Sticky media-changed and removal-request tracking
`timescale 1ns/100ps
`default_nettype none
module dtf_err_track
  import dtf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Events
  input wire logic mediaChangedIn,
  input wire logic removalRequestIn,
  input wire logic cmdAccept,
  input wire logic cmdDone,
  input wire dtf_result_type cmdResult,
  // State
  output logic mediaPending,
  output logic removalPending
);
  typedef struct packed {
    logic media;
    logic removal;
  } dtf_track_type;

  dtf_track_type st;
  dtf_track_type next_st;

  always_comb begin
    next_st = st;
    // First command after a change is rejected, then state clears
    if (cmdAccept && st.media) begin
      next_st.media = 1'b0;
    end
    if (cmdDone && cmdResult == DTF_RES_DOOR_CLEAR) begin
      next_st.removal = 1'b0;
    end
    // Set wins over clear
    if (mediaChangedIn) begin
      next_st.media = 1'b1;
    end
    if (removalRequestIn) begin
      next_st.removal = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mediaPending = st.media;
  assign removalPending = st.removal;
endmodule
`default_nettype wire

// ==== logic/dtf_taskfile.sv ====
// Host-visible task file register bank of a disk device
`timescale 1ns/100ps
`default_nettype none
`include "dtf_regs.svh"
module dtf_taskfile
  import dtf_pkg::*;
#(
  parameter int RESET_CYCLES = 8
)
(
  // Clock and hardware reset
  input wire logic mclk,
  input wire logic rst_n,
  // Strap: this drive's address
  input wire logic driveAddr,
  // Host register port
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic [7:0] ddIn,
  output logic [7:0] ddOut,
  output logic ddOe_n,
  // Interrupt request pin
  output logic hostIrqOut,
  output logic hostIrqOe_n,
  // Core command side
  output logic cmdStart,
  output logic [7:0] cmdCode,
  output logic [7:0] featureParameter,
  output logic lbaMode,
  output logic [8:0] sectorsRequested,
  output logic [3:0] headField,
  output logic [7:0] startSector,
  output logic softResetActive,
  input wire logic cmdDone,
  input wire dtf_result_type cmdResult,
  input wire logic [6:0] errorBits,
  input wire logic [7:0] diagCode,
  input wire logic [3:0] errHead,
  input wire logic [7:0] errSector,
  input wire logic [7:0] sectorsLeft,
  // Removable media events
  input wire logic mediaChangedIn,
  input wire logic removalRequestIn,
  // Status view
  output logic [7:0] statusOut
);
  // ==========================================================
  // State
  typedef struct packed {
    dtf_state_type state;
    logic [7:0] control;
    logic [7:0] drvHead;
    logic [7:0] errorCause;
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] command;
    logic errFlag;
    logic irqPending;
    logic start;
    logic [7:0] rdData;
    logic rdActive;
    logic wrPrev;
    logic rdPrev;
    logic [15:0] rstCnt;
    logic picked;
  } dtf_regs_type;

  dtf_regs_type r;
  dtf_regs_type next_r;

  logic mediaPending;
  logic removalPending;
  logic cmdAccept;

  // Full count, zero means 256
  function automatic logic [8:0] fullCount(input logic [7:0] c);
    fullCount = (c == 8'h00) ? 9'h100 : {1'b0, c};
  endfunction

  function automatic logic [7:0] errorWord(input logic [6:0] b);
    errorWord = {1'b0, b};
  endfunction

  // ==========================================================
  // Media event tracking
  dtf_err_track errTrack (
    .mclk(mclk),
    .rst_n(rst_n),
    .mediaChangedIn(mediaChangedIn),
    .removalRequestIn(removalRequestIn),
    .cmdAccept(cmdAccept),
    .cmdDone(cmdDone),
    .cmdResult(cmdResult),
    .mediaPending(mediaPending),
    .removalPending(removalPending)
  );

  // ==========================================================
  // Decode
  logic wrEdge;
  logic rdEdge;
  logic ctlSel;
  logic cmdSel;
  logic selected;
  logic busy;
  logic [7:0] status;

  assign wrEdge = !diow_n && !r.wrPrev;
  assign rdEdge = !dior_n && !r.rdPrev;
  assign ctlSel = cs0_n && !cs1_n;
  assign cmdSel = !cs0_n && cs1_n;
  assign selected = (r.drvHead[`DTF_DH_DEV] == driveAddr);
  // Soft reset bit shows busy at once, before the state follows
  assign busy = (r.state != DTF_IDLE) || r.control[`DTF_CTL_SOFT_RESET_BIT];
  always_comb begin
    status = 8'h00;
    status[`DTF_ST_BSY] = busy;
    status[`DTF_ST_ERR] = r.errFlag && !busy;
  end
  assign cmdAccept = r.start;

  // ==========================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.wrPrev = !diow_n;
    next_r.rdPrev = !dior_n;
    next_r.rdActive = !dior_n && selected && ((cmdSel && da != 3'h0) ||
        (ctlSel && da == `DTF_ADDR_CONTROL));
    // Host writes; control block goes to both drives
    if (wrEdge && ctlSel && da == `DTF_ADDR_CONTROL) begin
      next_r.control = {5'h00, ddIn[`DTF_CTL_SOFT_RESET_BIT], ddIn[`DTF_CTL_IRQ_DISABLE_BIT], 1'b0};
    end
    if (wrEdge && cmdSel && !busy) begin
      unique case (da)
        `DTF_ADDR_ERROR: next_r.feature = ddIn;
        `DTF_ADDR_COUNT: next_r.count = ddIn;
        `DTF_ADDR_SECTOR: next_r.sector = ddIn;
        `DTF_ADDR_DRVHEAD: next_r.drvHead = ddIn;
        `DTF_ADDR_STATUS: begin
          if (selected) begin
            next_r.command = ddIn;
            next_r.start = 1'b1;
            next_r.state = DTF_BUSY;
            next_r.errFlag = 1'b0;
            next_r.irqPending = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Status read acknowledges interrupt
    if (rdEdge && cmdSel && selected && da == `DTF_ADDR_STATUS) begin
      next_r.irqPending = 1'b0;
    end
    // Read data
    unique case (da)
      `DTF_ADDR_ERROR: next_r.rdData = r.errorCause;
      `DTF_ADDR_COUNT: next_r.rdData = r.count;
      `DTF_ADDR_SECTOR: next_r.rdData = r.sector;
      `DTF_ADDR_DRVHEAD: next_r.rdData = r.drvHead;
      `DTF_ADDR_STATUS: next_r.rdData = status;
      default: next_r.rdData = 8'h00;
    endcase
    // Command sequencing
    unique case (r.state)
      DTF_IDLE: begin
      end
      DTF_BUSY: begin
        if (r.start && mediaPending) begin
          next_r.errorCause = 8'h00;
          next_r.errorCause[`DTF_ERR_MC] = 1'b1;
          next_r.errFlag = 1'b1;
          next_r.irqPending = 1'b1;
          next_r.state = DTF_IDLE;
        end else if (cmdDone) begin
          next_r.state = DTF_IDLE;
          next_r.irqPending = 1'b1;
          unique case (cmdResult)
            DTF_RES_OK, DTF_RES_DOOR_CLEAR: begin
              next_r.count = 8'h00;
            end
            DTF_RES_MEDIA_ERR: begin
              next_r.errorCause = errorWord(errorBits);
              next_r.errFlag = 1'b1;
              next_r.count = sectorsLeft;
              next_r.sector = errSector;
              next_r.drvHead[`DTF_DH_HEAD_TOP:`DTF_DH_HEAD_BOT] = errHead;
            end
            DTF_RES_ABORT: begin
              next_r.errorCause = 8'h00;
              next_r.errorCause[`DTF_ERR_COMMAND_ABORTED_FLAG] = 1'b1;
              next_r.errFlag = 1'b1;
            end
            DTF_RES_DOOR_LOCK: begin
              if (removalPending) begin
                next_r.errorCause = 8'h00;
                next_r.errorCause[`DTF_ERR_MCR] = 1'b1;
                next_r.errFlag = 1'b1;
              end
            end
            DTF_RES_DIAG: next_r.errorCause = diagCode;
            default: begin
            end
          endcase
        end
      end
      DTF_RESET: begin
        if (r.rstCnt != 16'h0000) begin
          next_r.rstCnt = r.rstCnt - 16'h0001;
        end else if (!r.control[`DTF_CTL_SOFT_RESET_BIT]) begin
          next_r.state = DTF_IDLE;
        end
      end
      default: begin
      end
    endcase
    // Soft reset holds the device
    if (r.control[`DTF_CTL_SOFT_RESET_BIT]) begin
      next_r.state = DTF_RESET;
      next_r.rstCnt = RESET_CYCLES[15:0];
      next_r.errorCause = `DTF_DIAG_PASS;
      next_r.errFlag = 1'b0;
      next_r.irqPending = 1'b0;
      next_r.count = `DTF_RST_COUNT;
      next_r.sector = `DTF_RST_SECTOR;
      next_r.drvHead = `DTF_RST_DRVHEAD;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= DTF_RESET;
      r.rstCnt <= RESET_CYCLES[15:0];
      r.control <= `DTF_RST_CONTROL;
      r.drvHead <= `DTF_RST_DRVHEAD;
      r.errorCause <= `DTF_DIAG_PASS;
      r.count <= `DTF_RST_COUNT;
      r.sector <= `DTF_RST_SECTOR;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign ddOut = r.rdData;
  assign ddOe_n = !r.rdActive;
  assign hostIrqOut = r.irqPending;
  assign hostIrqOe_n = r.control[`DTF_CTL_IRQ_DISABLE_BIT] || !selected;
  assign cmdStart = r.start;
  assign cmdCode = r.command;
  assign featureParameter = r.feature;
  assign lbaMode = r.drvHead[`DTF_DH_LBA];
  assign sectorsRequested = fullCount(r.count);
  assign headField = r.drvHead[`DTF_DH_HEAD_TOP:`DTF_DH_HEAD_BOT];
  assign startSector = r.sector;
  assign softResetActive = r.control[`DTF_CTL_SOFT_RESET_BIT];
  assign statusOut = status;
endmodule
`default_nettype wire

// ==== tb/dtf_taskfile_chk.sv ====
// Assertion checker for the task file register port
`timescale 1ns/100ps
`default_nettype none
module dtf_taskfile_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Host port
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic [7:0] ddIn,
  input wire logic ddOe_n,
  input wire logic hostIrqOut,
  input wire logic hostIrqOe_n,
  // Core side
  input wire logic cmdStart,
  input wire logic cmdDone,
  input wire logic [8:0] sectorsRequested,
  input wire logic softResetActive,
  input wire logic [7:0] statusOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr;
    $fell(diow_n) && !cs1_n && cs0_n && da == 3'h6;
  endsequence
  sequence s_done;
    cmdDone && statusOut[7] && !softResetActive;
  endsequence
  AST_IRQ_OFF: assert property (s_ctl_wr ##0 ddIn[1] |=> hostIrqOe_n)
    else $error("irq enable not released");
  AST_SOFT_RESET_BIT_SET: assert property (s_ctl_wr ##0 ddIn[2] |=> softResetActive)
    else $error("soft reset not taken");
  AST_SOFT_RESET_BIT_BUSY: assert property (softResetActive |-> statusOut[7])
    else $error("not busy in soft reset");
  AST_COUNT: assert property (sectorsRequested[8] |-> sectorsRequested[7:0] == 8'h00)
    else $error("count above 256");
  AST_BUSY_WR: assert property ($fell(diow_n) && !cs0_n && statusOut[7] |=> !cmdStart)
    else $error("write taken while busy");
  AST_START: assert property (cmdStart |-> statusOut[7] && !hostIrqOut)
    else $error("command start without busy");
  AST_ERR_MASK: assert property (statusOut[7] |-> !statusOut[0])
    else $error("error flag while busy");
  AST_DONE: assert property (s_done |=> !statusOut[7] && hostIrqOut)
    else $error("completion not posted");
  AST_RD_OE: assert property (!ddOe_n |-> !$past(dior_n))
    else $error("data driven without read");
  AST_IRQ_ACK: assert property (!dior_n && !cs0_n && cs1_n && da == 3'h7 |=> !hostIrqOut)
    else $error("status read kept irq");
endmodule
`default_nettype wire

// ==== tb/dtf_host.sv ====
// Host adapter model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module dtf_host (
  // Clock
  input wire logic mclk,
  // Register strobes
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] da,
  output logic dior_n,
  output logic diow_n,
  output logic [7:0] ddIn
);
  initial {cs0_n, cs1_n, dior_n, diow_n, da, ddIn} = 15'h7800;
  // One access; writes held one edge, reads two
  task automatic acc(input logic ctl, input logic wrt, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    cs0_n <= ctl;
    cs1_n <= !ctl;
    da <= a;
    ddIn <= ctl ? {5'h00, d[2:1], 1'b0} : d;
    dior_n <= wrt;
    diow_n <= !wrt;
    repeat (wrt ? 1 : 2) @(posedge mclk);
    {cs0_n, cs1_n, dior_n, diow_n} <= 4'hF;
    ddIn <= ~ddIn;
  endtask
endmodule
`default_nettype wire

// ==== tb/disk_taskfile_regs_bench.sv ====
// Self-checking bench of the task file register bank
`timescale 1ns/100ps
`default_nettype none
module disk_taskfile_regs_bench;
  import dtf_pkg::*;
  logic mclk, rst_n, driveAddr, cmdDone, mediaChangedIn, removalRequestIn, oeWas;
  logic cs0_n, cs1_n, dior_n, diow_n, ddOe_n, hostIrqOut, hostIrqOe_n;
  logic cmdStart, lbaMode, softResetActive;
  logic [2:0] da;
  logic [3:0] errHead, headField;
  logic [6:0] errorBits;
  logic [8:0] sectorsRequested;
  logic [7:0] ddIn, ddOut, cmdCode, featureParameter, startSector, statusOut, r;
  logic [7:0] diagCode, errSector, sectorsLeft;
  logic [7:0] q[$];
  logic [6:0] eb[5] = '{7'h40, 7'h10, 7'h04, 7'h02, 7'h01};
  dtf_result_type cmdResult;
  int failures, check_count;
  dtf_host host(.*);
  dtf_taskfile #(.RESET_CYCLES(2)) uut(.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read results checked against the oldest note
  always @(posedge mclk) begin
    oeWas <= ddOe_n;
    if (oeWas && !ddOe_n && q.size() > 0) cmp("read", q.pop_front(), ddOut);
  end
  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    host.acc(c, 1'b1, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    q.push_back(e);
    host.acc(1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (statusOut[7] !== 1'b0 && n < 50);
    if (n == 50) begin
      failures++;
      $display("[FAIL] busy expected 0 seen 1");
    end
  endtask
  task automatic cmd(input dtf_result_type res, input logic [6:0] e);
    wr(0, 3'h7, 8'h20);
    #1 cmp("start", 1, cmdStart);
    cmp("code", 8'h20, cmdCode);
    wr(0, 3'h2, 8'h55);
    @(posedge mclk);
    {errHead, errSector, sectorsLeft, diagCode} <= 28'($urandom);
    {cmdResult, errorBits, cmdDone} <= {res, e, 1'b1};
    @(posedge mclk);
    cmdDone <= 1'b0;
    idle();
  endtask
  task automatic pulse(input logic m);
    @(posedge mclk);
    {mediaChangedIn, removalRequestIn} <= {m, !m};
    @(posedge mclk);
    {mediaChangedIn, removalRequestIn} <= 2'b00;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rst_n, driveAddr, cmdDone, mediaChangedIn, removalRequestIn, oeWas} = 6'h01;
    {errorBits, diagCode, errHead, errSector, sectorsLeft} = 35'h0;
    cmdResult = DTF_RES_OK;
    {failures, check_count} = 64'h0;
    void'($urandom(32'hD30D7610));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    idle();
    rd(3'h1, 8'h01);
    r = 8'($urandom);
    wr(0, 3'h2, 8'h00);
    wr(0, 3'h3, r);
    wr(0, 3'h6, {4'hE, r[3:0]});
    wr(0, 3'h1, r ^ 8'h5A);
    #1 cmp("count", 9'h100, sectorsRequested);
    cmp("lba", 1, lbaMode);
    cmp("head", r[3:0], headField);
    cmp("sector", r, startSector);
    cmp("feature", r ^ 8'h5A, featureParameter);
    rd(3'h3, r);
    $display("register test done");
    wr(1, 3'h6, 8'h00);
    #1 cmp("irq oe", 0, hostIrqOe_n);
    wr(1, 3'h6, 8'h02);
    #1 cmp("irq oe", 1, hostIrqOe_n);
    wr(1, 3'h6, 8'h00);
    wr(0, 3'h6, 8'hB0);
    #1 cmp("irq oe", 1, hostIrqOe_n);
    wr(0, 3'h7, 8'h20);
    #1 cmp("start", 0, cmdStart);
    wr(0, 3'h6, 8'hA0);
    $display("select test done");
    foreach (eb[i]) begin
      cmd(DTF_RES_MEDIA_ERR, eb[i]);
      cmp("err flag", 1, statusOut[0]);
      rd(3'h1, {1'b0, eb[i]});
      rd(3'h2, sectorsLeft);
      rd(3'h3, errSector);
      rd(3'h6, {4'hA, errHead});
    end
    host.acc(1'b0, 1'b0, 3'h7, 8'h00);
    #1 cmp("irq", 0, hostIrqOut);
    cmd(DTF_RES_OK, 7'h00);
    cmp("err flag", 0, statusOut[0]);
    rd(3'h2, 8'h00);
    $display("media error test done");
    pulse(1'b1);
    wr(0, 3'h7, 8'h20);
    idle();
    cmp("err flag", 1, statusOut[0]);
    rd(3'h1, 8'h20);
    cmd(DTF_RES_OK, 7'h00);
    cmp("err flag", 0, statusOut[0]);
    pulse(1'b0);
    cmd(DTF_RES_DOOR_LOCK, 7'h00);
    rd(3'h1, 8'h08);
    cmd(DTF_RES_DOOR_CLEAR, 7'h00);
    cmd(DTF_RES_DOOR_LOCK, 7'h00);
    cmp("err flag", 0, statusOut[0]);
    cmd(DTF_RES_DIAG, 7'h00);
    rd(3'h1, diagCode);
    $display("removable test done");
    wr(1, 3'h6, 8'h04);
    #1 cmp("soft_reset_bit", 1, softResetActive);
    wr(1, 3'h6, 8'h00);
    idle();
    rd(3'h1, 8'h01);
    $display("soft reset test done");
    results();
  end
  initial begin
    #100us;
    failures++;
    results();
  end
endmodule
bind dtf_taskfile dtf_taskfile_chk chk(.*);
`default_nettype wire
